// *** logic/wgt_pkg.sv ***
// Notes on behaviour
// R1: Step clock is 8 MHz divided by 13, 3 and 8; divide-by-13 wraps at 13.
// R2: Divide-by-3 output is asymmetric and times the converter strobes.
// R3: Eight-bit address counter advances once per step; 256 steps per period. Code skips the step while the DAC buffer is full.
// R4: A 1.625 us step pulse from divide-by-8 and divide-by-3 adds one count.
// R5: DAC latch strobe comes 3.25 us after the step that changed the address.
// R6: Host write loads the counter from A1..A8 and drives RAM address directly.
// R7: Write cycles with A23 high are RAM writes; reads with A23 are ignored.
// R8: Host sets address and data before direction and strobes go active.
// R9: With address strobe on and acknowledge off, byte strobes write low 8, high 4.
// R10: Host side acknowledge ends each write; host then drops address strobe.
// R11: RAM holds 256 words of 12 bits; all eight address bits select a word.
// R12: After a host write counting resumes from the loaded address.
// R13: Frame start rises on wrap after 256 counts and ends with next step.
// R14: Read/convert select high during first converter strobe, low during second.
// R15: The two converter strobes are 1.625 us apart.
// R16: Timing pulses come from the 0.625 us divide-by-13 drive pulse.
// R17: Two-stage delay sequencer: arm at eighth count, set, shift, clear, idle.
// R18: Select rises with first pulse, held by stage one, drops after second pulse.
// R19: Latch strobe is stage one and second pulse; it is first converter strobe.
// R20: Third pulse forms second converter strobe; its end clears stage two.
// R21: DAC takes the full 12-bit word in one transfer on the latch strobe.
// R22: Latch strobe is also the digitizer sample RAM write enable.
// R23: Reset clears dividers, address counter and both delay stages.
package wgt_pkg;
	localparam int REF_CLK_HZ = 20000000;
	localparam int SYS_CLK_HZ = 8000000;
	localparam int TICK_GCD = 4000000;
	localparam logic [2:0] TICK_INC = 3'(SYS_CLK_HZ / TICK_GCD);
	localparam logic [2:0] TICK_MOD = 3'(REF_CLK_HZ / TICK_GCD);
	localparam logic [3:0] DIV13_LAST = 4'hC;
	localparam logic [1:0] DIV3_LAST = 2'h2;
	localparam logic [2:0] DIV8_LAST = 3'h7;
	localparam int DRIVE_PULSE_NS = 625;
	localparam logic [3:0] DRIVE_PULSE_TICKS = 4'((DRIVE_PULSE_NS * (SYS_CLK_HZ / 1000000)) / 1000);
	localparam logic [1:0] DIV3_OUT_STATE = 2'h2;
	localparam logic [2:0] STEP_DIV8 = 3'h6;
	localparam logic [2:0] ARM_DIV8 = 3'h7;
	localparam logic [1:0] ARM_DIV3 = 2'h0;
	localparam int ADDR_W = 8;
	localparam int WORD_W = 12;
	localparam int RAM_DEPTH = 256;
	localparam int LOW_BYTE_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_LAST = 8'hFF;
	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b001,
		SEQ_FIRST = 3'b010,
		SEQ_SECOND = 3'b100
	} wgt_seq_t;
endpackage

// *** logic/waveform_generator_timing.sv ***
`timescale 1ns/1ps
module waveform_generator_timing (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic addressValidStrobeN,
	input wire logic upperByteStrobeN,
	input wire logic lowerByteStrobeN,
	input wire logic readWriteN,
	input wire logic hostA23,
	input wire logic [wgt_pkg::ADDR_W-1:0] hostAddr,
	input wire logic [wgt_pkg::WORD_W-1:0] hostData,
	input wire logic transferAcknowledgeN,
	input wire logic dacReady,
	output logic [wgt_pkg::WORD_W-1:0] dacWord,
	output logic dacValid,
	output logic latchStrobeN,
	output logic convStrobeN,
	output logic readConvertSel,
	output logic frameStartPulse,
	output logic [wgt_pkg::ADDR_W-1:0] ramAddr
);
	localparam int SYNC_W = 6 + wgt_pkg::ADDR_W + wgt_pkg::WORD_W;

	logic [SYNC_W-1:0] syncA_ff;
	logic [SYNC_W-1:0] syncB_ff;
	logic [2:0] tickAcc_ff, nxt_tickAcc;
	logic tick;
	logic [3:0] div13_ff, nxt_div13;
	logic [1:0] div3_ff, nxt_div3;
	logic [2:0] div8_ff, nxt_div8;
	logic [wgt_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
	logic stepWin_ff, nxt_stepWin;
	logic stepDone_ff, nxt_stepDone;
	logic frame_ff, nxt_frame;
	wgt_pkg::wgt_seq_t seq_ff, nxt_seq;
	logic pulse, pulseEnd, armNow, stepRise, latchNow, latchPrev_ff;
	logic hostWr, wrLow, wrHigh, bufReady, push, pop;
	logic sAs, sUds, sLds, sRw, sA23, sAck;
	logic [wgt_pkg::ADDR_W-1:0] sAddr;
	logic [wgt_pkg::WORD_W-1:0] sData;
	logic [wgt_pkg::WORD_W-1:0] ram [0:wgt_pkg::RAM_DEPTH-1];
	logic [wgt_pkg::WORD_W-1:0] head_ff, nxt_head, tail_ff, nxt_tail;
	logic headV_ff, nxt_headV, tailV_ff, nxt_tailV;
	logic latchN_ff, nxt_latchN, convN_ff, nxt_convN, rc_ff, nxt_rc;
	logic [wgt_pkg::ADDR_W-1:0] ramAddr_ff, nxt_ramAddr;

	// Host pins cross two flops; data settles before strobes arrive
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			syncA_ff <= '1;
			syncB_ff <= '1;
		end else begin
			syncA_ff <= {addressValidStrobeN, upperByteStrobeN, lowerByteStrobeN, readWriteN,
				hostA23, transferAcknowledgeN, hostAddr, hostData};
			syncB_ff <= syncA_ff; // R8
		end
	end
	assign {sAs, sUds, sLds, sRw, sA23, sAck, sAddr, sData} = syncB_ff;

	// Host write decode
	always_comb begin
		hostWr = !sAs && !sRw && sA23 && sAck; // R7
		wrLow = hostWr && !sLds; // R9
		wrHigh = hostWr && !sUds; // R9
	end

	// System clock ticks and divider chain
	always_comb begin
		tick = 1'b0;
		nxt_tickAcc = tickAcc_ff + wgt_pkg::TICK_INC;
		if (nxt_tickAcc >= wgt_pkg::TICK_MOD) begin
			nxt_tickAcc = nxt_tickAcc - wgt_pkg::TICK_MOD;
			tick = 1'b1;
		end
		nxt_div13 = div13_ff;
		nxt_div3 = div3_ff;
		nxt_div8 = div8_ff;
		if (tick) begin
			if (div13_ff == wgt_pkg::DIV13_LAST) begin
				nxt_div13 = 4'h0; // R1
				if (div3_ff == wgt_pkg::DIV3_LAST) begin
					nxt_div3 = 2'h0;
					nxt_div8 = div8_ff + 3'h1; // R1
				end else begin
					nxt_div3 = div3_ff + 2'h1;
				end
			end else begin
				nxt_div13 = div13_ff + 4'h1;
			end
		end
		pulse = div13_ff < wgt_pkg::DRIVE_PULSE_TICKS; // R16
		pulseEnd = tick && (div13_ff == wgt_pkg::DRIVE_PULSE_TICKS - 4'h1);
		armNow = (div8_ff == wgt_pkg::ARM_DIV8) && (div3_ff == wgt_pkg::ARM_DIV3); // R17
		nxt_stepWin = (div8_ff == wgt_pkg::STEP_DIV8) && (div3_ff == wgt_pkg::DIV3_OUT_STATE); // R2 R4
		stepRise = nxt_stepWin && !stepWin_ff;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tickAcc_ff <= 3'h0;
			div13_ff <= 4'h0; // R23
			div3_ff <= 2'h0;
			div8_ff <= 3'h0;
			stepWin_ff <= 1'b0;
		end else begin
			tickAcc_ff <= nxt_tickAcc;
			div13_ff <= nxt_div13;
			div3_ff <= nxt_div3;
			div8_ff <= nxt_div8;
			stepWin_ff <= nxt_stepWin;
		end
	end

	// Delay sequencer
	always_comb begin
		nxt_seq = seq_ff;
		if (pulseEnd) begin
			unique case (seq_ff)
				wgt_pkg::SEQ_IDLE: begin
					if (armNow) begin
						nxt_seq = wgt_pkg::SEQ_FIRST; // R17
					end
				end
				wgt_pkg::SEQ_FIRST: begin
					nxt_seq = wgt_pkg::SEQ_SECOND; // R17
				end
				wgt_pkg::SEQ_SECOND: begin
					nxt_seq = wgt_pkg::SEQ_IDLE; // R20
				end
				default: begin
					nxt_seq = wgt_pkg::SEQ_IDLE;
				end
			endcase
		end
		latchNow = (seq_ff == wgt_pkg::SEQ_FIRST) && pulse; // R19
		nxt_rc = (seq_ff == wgt_pkg::SEQ_IDLE && armNow && pulse)
			|| (seq_ff == wgt_pkg::SEQ_FIRST); // R14 R18
		nxt_latchN = !latchNow; // R22
		nxt_convN = !(latchNow || (seq_ff == wgt_pkg::SEQ_SECOND && pulse)); // R15 R20
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			seq_ff <= wgt_pkg::SEQ_IDLE; // R23
			latchPrev_ff <= 1'b0;
			rc_ff <= 1'b0;
			latchN_ff <= 1'b1;
			convN_ff <= 1'b1;
		end else begin
			seq_ff <= nxt_seq;
			latchPrev_ff <= latchNow;
			rc_ff <= nxt_rc;
			latchN_ff <= nxt_latchN;
			convN_ff <= nxt_convN;
		end
	end

	// Address counter, host load and frame start
	always_comb begin
		nxt_addr = addr_ff;
		nxt_stepDone = stepDone_ff;
		nxt_frame = frame_ff;
		nxt_ramAddr = addr_ff;
		push = latchNow && !latchPrev_ff && stepDone_ff; // R5
		if (push) begin
			nxt_stepDone = 1'b0;
		end
		if (hostWr) begin
			nxt_addr = sAddr; // R6 R12
			nxt_ramAddr = sAddr; // R6
		end else if (stepRise && bufReady) begin
			nxt_addr = addr_ff + 8'h01; // R3 R4
			nxt_ramAddr = nxt_addr;
			nxt_stepDone = 1'b1;
			nxt_frame = (addr_ff == wgt_pkg::ADDR_LAST); // R13
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			addr_ff <= 8'h00; // R23
			stepDone_ff <= 1'b0;
			frame_ff <= 1'b0;
			ramAddr_ff <= 8'h00;
		end else begin
			addr_ff <= nxt_addr;
			stepDone_ff <= nxt_stepDone;
			frame_ff <= nxt_frame;
			ramAddr_ff <= nxt_ramAddr;
		end
	end

	// Waveform RAM; all 256 words of the memory are implemented
	always_ff @(posedge ref_clk) begin
		if (wrLow) begin
			ram[sAddr][wgt_pkg::LOW_BYTE_W-1:0] <= sData[wgt_pkg::LOW_BYTE_W-1:0]; // R9 R11
		end
		if (wrHigh) begin
			ram[sAddr][wgt_pkg::WORD_W-1:wgt_pkg::LOW_BYTE_W] <=
				sData[wgt_pkg::WORD_W-1:wgt_pkg::LOW_BYTE_W]; // R9 R11
		end
	end

	// Two-entry buffer toward the DAC; a full buffer stalls stepping
	always_comb begin
		bufReady = !tailV_ff;
		pop = headV_ff && dacReady;
		nxt_head = head_ff;
		nxt_headV = headV_ff;
		nxt_tail = tail_ff;
		nxt_tailV = tailV_ff;
		if (pop) begin
			if (tailV_ff) begin
				nxt_head = tail_ff;
				nxt_tailV = 1'b0;
			end else begin
				nxt_headV = 1'b0;
			end
		end
		if (push) begin
			if (!nxt_headV) begin
				nxt_head = ram[addr_ff]; // R21
				nxt_headV = 1'b1;
			end else begin
				nxt_tail = ram[addr_ff]; // R21
				nxt_tailV = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			head_ff <= 12'h000;
			tail_ff <= 12'h000;
			headV_ff <= 1'b0;
			tailV_ff <= 1'b0;
		end else begin
			head_ff <= nxt_head;
			tail_ff <= nxt_tail;
			headV_ff <= nxt_headV;
			tailV_ff <= nxt_tailV;
		end
	end

	assign dacWord = head_ff;
	assign dacValid = headV_ff;
	assign latchStrobeN = latchN_ff;
	assign convStrobeN = convN_ff;
	assign readConvertSel = rc_ff;
	assign frameStartPulse = frame_ff;
	assign ramAddr = ramAddr_ff;
endmodule

// *** verif/wgt_timing_properties.sv ***
`timescale 1ns/1ps
module wgt_timing_properties (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic addressValidStrobeN,
	input wire logic dacReady,
	input wire logic [11:0] dacWord,
	input wire logic dacValid,
	input wire logic latchStrobeN,
	input wire logic convStrobeN,
	input wire logic readConvertSel,
	input wire logic frameStartPulse,
	input wire logic [7:0] ramAddr
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence latchFall;
		$fell(latchStrobeN);
	endsequence
	sequence convStart;
		$fell(convStrobeN) && !readConvertSel;
	endsequence
	sequence hostIdle;
		addressValidStrobeN && $past(addressValidStrobeN, 4);
	endsequence
	reset_quiet_a: assert property (disable iff (1'b0) rst |=> convStrobeN && latchStrobeN)
		else $error("strobe active after reset");
	latch_conv_a: assert property (!latchStrobeN |-> !convStrobeN && readConvertSel)
		else $error("latch strobe without read strobe");
	conv_gap_a: assert property (latchFall |-> ##[31:34] convStart)
		else $error("second converter strobe misplaced");
	step_inc_a: assert property ($changed(ramAddr) and hostIdle |-> ramAddr == $past(ramAddr) + 8'h01)
		else $error("address step not one");
	latch_delay_a: assert property ($changed(ramAddr) and hostIdle |-> ##[63:67] latchFall)
		else $error("latch strobe not 3.25 us after step");
	frame_wrap_a: assert property ($rose(frameStartPulse) |-> ramAddr == 8'h00)
		else $error("frame start off wrap");
	rc_lead_a: assert property ($rose(readConvertSel) |-> ##[31:34] latchFall)
		else $error("select not leading latch by one pulse");
	dac_hold_a: assert property (dacValid && !dacReady |=> dacValid && $stable(dacWord))
		else $error("word lost during stall");
endmodule
bind waveform_generator_timing wgt_timing_properties chk (.ref_clk, .rst, .addressValidStrobeN,
	.dacReady, .dacWord, .dacValid, .latchStrobeN, .convStrobeN, .readConvertSel,
	.frameStartPulse, .ramAddr);

// *** verif/wgt_partner.sv ***
`timescale 1ns/1ps
module wgt_partner (
	input wire logic ref_clk,
	input wire logic addressValidStrobeN,
	input wire logic stall,
	output logic transferAcknowledgeN,
	output logic dacReady
);
	logic [2:0] waitCnt;
	initial begin
		waitCnt = 3'h0;
		transferAcknowledgeN = 1'h1;
		dacReady = 1'h1;
	end
	// Acknowledge a few cycles into each strobe
	always @(posedge ref_clk) begin
		waitCnt <= (addressValidStrobeN || waitCnt == 3'h6)
			? waitCnt & {3{!addressValidStrobeN}} : waitCnt + 3'h1;
		transferAcknowledgeN <= addressValidStrobeN || waitCnt != 3'h6;
		dacReady <= !stall;
	end
endmodule

// *** verif/test_waveform_generator_timing.sv ***
`timescale 1ns/1ps
module test_waveform_generator_timing;
	typedef struct {logic [7:0] a; logic [11:0] d; logic sel, rw, loN, upN, ld;} wgt_row_t;
	logic ref_clk = 1'h0, rst = 1'h1, addressValidStrobeN = 1'h1, upperByteStrobeN = 1'h1;
	logic lowerByteStrobeN = 1'h1, readWriteN = 1'h1, hostA23 = 1'h0, stall = 1'h0;
	logic [7:0] hostAddr = 8'h00, ramAddr, a;
	logic [11:0] hostData = 12'h000, dacWord;
	logic transferAcknowledgeN, dacReady, dacValid, latchStrobeN, convStrobeN;
	logic readConvertSel, frameStartPulse;
	logic [11:0] q[$];
	int n_mismatch = 0, n_checks = 0, frameCycles = 0;
	wgt_row_t rows [8] = '{'{8'h00, 12'h123, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1},
		'{8'h00, 12'hAEE, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1},
		'{8'hFF, 12'h7C1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1},
		'{8'hFF, 12'h912, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1},
		'{8'h80, 12'hFFF, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0},
		'{8'h80, 12'hFFF, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0},
		'{8'hFE, 12'h5A3, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1},
		'{8'hFD, 12'h2B4, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1}};
	waveform_generator_timing DUT (.ref_clk, .rst, .addressValidStrobeN, .upperByteStrobeN,
		.lowerByteStrobeN, .readWriteN, .hostA23, .hostAddr, .hostData, .transferAcknowledgeN,
		.dacReady, .dacWord, .dacValid, .latchStrobeN, .convStrobeN, .readConvertSel,
		.frameStartPulse, .ramAddr);
	wgt_partner partner (.ref_clk, .addressValidStrobeN, .stall, .transferAcknowledgeN, .dacReady);
	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (dacValid && dacReady) q.push_back(dacWord);
		if (frameStartPulse) frameCycles <= frameCycles + 1;
	end
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic host_cycle(input wgt_row_t r);
		int k;
		@(posedge ref_clk);
		hostAddr <= r.a;
		hostData <= r.d;
		hostA23 <= r.sel;
		repeat (3) @(posedge ref_clk);
		readWriteN <= r.rw;
		addressValidStrobeN <= 1'h0;
		lowerByteStrobeN <= r.loN;
		upperByteStrobeN <= r.upN;
		repeat (5) @(posedge ref_clk);
		check({11'h0, ramAddr == r.a}, {11'h0, r.ld});
		for (k = 0; k < 20 && transferAcknowledgeN; k++) @(posedge ref_clk);
		addressValidStrobeN <= 1'h1;
		lowerByteStrobeN <= 1'h1;
		upperByteStrobeN <= 1'h1;
		readWriteN <= 1'h1;
		@(posedge ref_clk);
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		rst <= 1'h0;
		repeat (10) @(posedge ref_clk);
		foreach (rows[i]) host_cycle(rows[i]);
		q.delete();
		repeat (3200) @(posedge ref_clk);
		check(q[0], 12'h5A3);
		check(q[1], 12'h9C1);
		check(q[2], 12'h1EE);
		check(12'(frameCycles), 12'h30C);
		stall <= 1'h1;
		a = ramAddr;
		repeat (3200) @(posedge ref_clk);
		check({4'h0, ramAddr}, {4'h0, a + 8'h02});
		check({11'h0, dacValid}, 12'h001);
		stall <= 1'h0;
		repeat (20) @(posedge ref_clk);
		check({11'h0, dacValid}, 12'h000);
		rst <= 1'h1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'h0;
		#1 check({ramAddr, convStrobeN, latchStrobeN, readConvertSel, dacValid}, 12'h00C);
		repeat (5) @(posedge ref_clk);
		check({4'h0, ramAddr}, 12'h000);
		give_verdict;
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		give_verdict;
	end
endmodule
